// ==== hdl/twu_pkg.sv ====
/*
  Constants, types and field layouts of the two-wire master receiver.
  Assumes a 10 MHz core clock and a 32-bit AHB-Lite register bus.
*/
// Summary of operation
// - Master mode only after START; address picks direction.
// - Status codes assume prescaler bits masked to zero.
// - START generated once the bus is free.
// - After START set flag, report 0x08.
// - After read address set flag: 0x38/0x40/0x48.
// - Received byte in data register when flag sets.
// - STOP request sends STOP, clears stop_request.
// - Repeated START request keeps the bus held.
// - Repeated START reports 0x10; either direction follows.
// - On 0x38 release bus, or START when free.
// - On 0x40/0x50 receive byte; ACK per ack_enable.
// - On 0x48/0x58 repeated START, STOP, or both.
package twu_pkg;
  // Bus timing: half an SCL period, rounded up to whole core cycles.
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_HALF_NS   = 5000;
  localparam int HALF_CYC      =
    (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 12;

  // Register word offsets (byte addresses).
  localparam logic [7:0] CONTROL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] DATA_OFS    = 8'h08;
  localparam logic [7:0] IRQ_ST_OFS  = 8'h0c;
  localparam logic [7:0] IRQ_EN_OFS  = 8'h10;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h14;

  // Reset values and field positions.
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST    = 8'hff;
  localparam int         PRESC_W     = 2;
  localparam int         EV_W        = 3;
  localparam int         EV_DONE     = 0;
  localparam int         EV_LOST     = 1;
  localparam int         EV_WCOL     = 2;
  localparam logic [3:0] LAST_BIT    = 4'h8;

  // Status codes, prescaler bits taken as zero.
  localparam logic [7:0] CODE_START   = 8'h08;
  localparam logic [7:0] CODE_RSTART  = 8'h10;
  localparam logic [7:0] CODE_AW_ACK  = 8'h18;
  localparam logic [7:0] CODE_AW_NACK = 8'h20;
  localparam logic [7:0] CODE_TX_ACK  = 8'h28;
  localparam logic [7:0] CODE_TX_NACK = 8'h30;
  localparam logic [7:0] CODE_LOST    = 8'h38;
  localparam logic [7:0] CODE_AR_ACK  = 8'h40;
  localparam logic [7:0] CODE_AR_NACK = 8'h48;
  localparam logic [7:0] CODE_RX_ACK  = 8'h50;
  localparam logic [7:0] CODE_RX_NACK = 8'h58;
  localparam logic [7:0] CODE_IDLE    = 8'hf8;

  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic op_done_flag;
    logic ack_enable;
    logic start_request;
    logic stop_request;
    logic write_collision;
    logic iface_enable;
    logic rsvd;
    logic irq_enable;
  } control_s;

  typedef enum logic [10:0] {
    S_IDLE = 11'h001,
    S_WAIT = 11'h002,
    S_STA  = 11'h004,
    S_HOLD = 11'h008,
    S_LOW  = 11'h010,
    S_HIGH = 11'h020,
    S_RSA  = 11'h040,
    S_RSB  = 11'h080,
    S_STPA = 11'h100,
    S_STPB = 11'h200,
    S_STPC = 11'h400
  } state_e;

  // Bit engine: sda and scl are "pull the line low" flags.
  typedef struct packed {
    state_e     state;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic       sda;
    logic       scl;
    logic [7:0] code;
    logic       rep;
    logic       master;
    logic       rx;
    logic       addr;
    logic       rd;
  } eng_s;

  localparam eng_s ENG_RST = '{state: S_IDLE, bitn: 4'h0, shift: 8'h00,
    sda: 1'h0, scl: 1'h0, code: CODE_IDLE, rep: 1'h0, master: 1'h0,
    rx: 1'h0, addr: 1'h0, rd: 1'h0};
endpackage : twu_pkg

// ==== hdl/twu_master_rx.sv ====
/*
  Two-wire master receiver (with the shared transmit path) behind an
  AHB-Lite slave. Assumes open-drain pads outside, resolved from the
  enables, and a bus master that only issues single word transfers.
*/
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module twu_master_rx #(
  parameter int HALF_CYC_P = twu_pkg::HALF_CYC
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CE_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic        HREADY_I,
  input  wire logic [31:0] HWDATA_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE_O,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  output logic             IRQ_O
);
  import twu_pkg::*;

  localparam logic [CNT_W-1:0] HALF_M1 = CNT_W'(HALF_CYC_P - 1);
  localparam logic [CNT_W-1:0] QTR     = CNT_W'(HALF_CYC_P / 2);

  control_s           ctl;
  control_s           next_ctl;
  eng_s               eng;
  eng_s               next_eng;
  logic [CNT_W-1:0]   cnt;
  logic [CNT_W-1:0]   next_cnt;
  logic [7:0]         data_reg;
  logic [PRESC_W-1:0] presc;
  logic [EV_W-1:0]    irq_st;
  logic [EV_W-1:0]    irq_en;
  logic               scl_s1;
  logic               scl_s;
  logic               sda_s1;
  logic               sda_s;
  logic               sda_d;
  logic               busy;
  logic               wr_pend;
  logic [7:0]         wr_addr;
  logic [31:0]        rdata;
  logic               done_set;
  logic               lost;
  logic               stop_clr;

  // The pads only ever pull low; a released line floats high.
  assign SCL_O       = 1'h0;
  assign SDA_O       = 1'h0;
  assign SCL_OE_O    = eng.scl;
  assign SDA_OE_O    = eng.sda;
  assign HREADYOUT_O = 1'h1;
  assign HRESP_O     = 1'h0;
  assign HRDATA_O    = rdata;

  // Both lines come from outside, so two flops before any use.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_s1 <= 1'h1;
      scl_s  <= 1'h1;
      sda_s1 <= 1'h1;
      sda_s  <= 1'h1;
      sda_d  <= 1'h1;
    end else if (CE_I) begin
      scl_s1 <= SCL_I;
      scl_s  <= scl_s1;
      sda_s1 <= SDA_I;
      sda_s  <= sda_s1;
      sda_d  <= sda_s;
    end
  end

  // START and STOP seen on the bus track whether another master owns it.
  wire start_det = scl_s & sda_d & ~sda_s;
  wire stop_det  = scl_s & ~sda_d & sda_s;

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy <= 1'h0;
    end else if (CE_I) begin
      busy <= start_det | (busy & ~stop_det);
    end
  end

  // Bus decode; the low address byte selects, upper bits alias.
  wire ahb_sel  = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire wr_ctl   = wr_pend & (wr_addr == CONTROL_OFS);
  wire wr_stat  = wr_pend & (wr_addr == STATUS_OFS);
  wire wr_data  = wr_pend & (wr_addr == DATA_OFS);
  wire wr_ien   = wr_pend & (wr_addr == IRQ_EN_OFS);
  wire wr_iclr  = wr_pend & (wr_addr == IRQ_CLR_OFS);
  wire [7:0] wd = HWDATA_I[7:0];
  wire [7:0] ra = HADDR_I[7:0];
  wire [7:0] stat_rd = {eng.code[7:3], 1'h0, presc};
  wire [31:0] rd_val =
    (ra == CONTROL_OFS) ? {24'h0, ctl} :
    (ra == STATUS_OFS)  ? {24'h0, stat_rd} :
    (ra == DATA_OFS)    ? {24'h0, data_reg} :
    (ra == IRQ_ST_OFS)  ? {29'h0, irq_st} :
    (ra == IRQ_EN_OFS)  ? {29'h0, irq_en} : 32'h0;

  // Read data is captured at the address phase, so it stands in the
  // data phase straight from a flop with no wait state.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_pend <= 1'h0;
      wr_addr <= 8'h00;
      rdata   <= 32'h0;
    end else if (CE_I) begin
      wr_pend <= ahb_sel & HWRITE_I;
      if (ahb_sel) wr_addr <= ra;
      if (ahb_sel & ~HWRITE_I) rdata <= rd_val;
    end
  end

  // Half-period timer; it stays at zero while a slave stretches SCL.
  wire tick     = (cnt == HALF_M1);
  wire qtr      = (cnt == QTR);
  wire wait_scl = ~scl_s & ((eng.state == S_HIGH) |
                  (eng.state == S_RSB) | (eng.state == S_STPB));
  assign next_cnt = (tick | wait_scl | (next_eng.state != eng.state)) ?
                    '0 : cnt + 1'h1;

  // Per-bit drive: address and write data bits, then ACK when reading.
  wire last   = (eng.bitn == LAST_BIT);
  wire drv    = last ? (eng.rx & ctl.ack_enable)
                     : (~eng.rx & ~eng.shift[7]);
  wire own    = last ? eng.rx : ~eng.rx;
  wire arb    = own & ~eng.sda & ~sda_s;
  wire ack_in = ~sda_s;
  wire c_addr = (eng.code == CODE_START) | (eng.code == CODE_RSTART);
  wire c_rx   = (eng.code == CODE_AR_ACK) | (eng.code == CODE_RX_ACK);
  wire c_tx   = (eng.code == CODE_AW_ACK) | (eng.code == CODE_AW_NACK) |
                (eng.code == CODE_TX_ACK) | (eng.code == CODE_TX_NACK);
  wire go_start = ctl.iface_enable & ctl.start_request & ~ctl.op_done_flag;
  wire [7:0] addr_code = eng.rd ? (ack_in ? CODE_AR_ACK : CODE_AR_NACK)
                                : (ack_in ? CODE_AW_ACK : CODE_AW_NACK);
  wire [7:0] data_code = eng.rx ? (eng.sda ? CODE_RX_ACK : CODE_RX_NACK)
                                : (ack_in ? CODE_TX_ACK : CODE_TX_NACK);

  // Bus engine: one state per half period of SCL.
  always_comb begin
    next_eng = eng;
    done_set = 1'h0;
    lost     = 1'h0;
    stop_clr = 1'h0;
    case (eng.state)
      S_IDLE: begin
        if (go_start) next_eng.state = S_WAIT;
      end
      S_WAIT: begin
        if (!busy) begin
          next_eng.state = S_STA;
          next_eng.sda   = 1'h1;
        end
      end
      S_STA: begin
        if (tick) begin
          next_eng.state  = S_HOLD;
          next_eng.scl    = 1'h1;
          next_eng.code   = eng.rep ? CODE_RSTART : CODE_START;
          next_eng.rep    = 1'h0;
          next_eng.master = 1'h1;
          done_set        = 1'h1;
        end
      end
      S_HOLD: begin
        // SCL stays low here until software clears the flag.
        if (!ctl.op_done_flag) begin
          if (ctl.stop_request) begin
            next_eng.state = S_STPA;
          end else if (ctl.start_request) begin
            next_eng.state = S_RSA;
          end else if (c_addr | c_rx | c_tx) begin
            next_eng.state = S_LOW;
            next_eng.bitn  = 4'h0;
            next_eng.shift = data_reg;
            next_eng.addr  = c_addr;
            next_eng.rx    = c_rx;
            if (c_addr) next_eng.rd = data_reg[0];
          end
        end
      end
      S_LOW: begin
        // SDA moves a quarter period after SCL falls, never with it.
        if (qtr) next_eng.sda = drv;
        if (tick) begin
          next_eng.state = S_HIGH;
          next_eng.scl   = 1'h0;
        end
      end
      S_HIGH: begin
        if (tick) begin
          if (arb) begin
            next_eng.state  = S_IDLE;
            next_eng.sda    = 1'h0;
            next_eng.code   = CODE_LOST;
            next_eng.master = 1'h0;
            lost            = 1'h1;
            done_set        = 1'h1;
          end else if (last) begin
            next_eng.state = S_HOLD;
            next_eng.scl   = 1'h1;
            next_eng.code  = eng.addr ? addr_code : data_code;
            done_set       = 1'h1;
          end else begin
            next_eng.state = S_LOW;
            next_eng.scl   = 1'h1;
            next_eng.bitn  = eng.bitn + 4'h1;
            next_eng.shift = {eng.shift[6:0], sda_s};
          end
        end
      end
      S_RSA: begin
        if (qtr) next_eng.sda = 1'h0;
        if (tick) begin
          next_eng.state = S_RSB;
          next_eng.scl   = 1'h0;
        end
      end
      S_RSB: begin
        if (tick) begin
          next_eng.state = S_STA;
          next_eng.sda   = 1'h1;
          next_eng.rep   = 1'h1;
        end
      end
      S_STPA: begin
        if (qtr) next_eng.sda = 1'h1;
        if (tick) begin
          next_eng.state = S_STPB;
          next_eng.scl   = 1'h0;
        end
      end
      S_STPB: begin
        if (tick) begin
          next_eng.state = S_STPC;
          next_eng.sda   = 1'h0;
        end
      end
      S_STPC: begin
        if (tick) begin
          next_eng.state  = ctl.start_request ? S_WAIT : S_IDLE;
          next_eng.code   = CODE_IDLE;
          next_eng.master = 1'h0;
          stop_clr        = 1'h1;
        end
      end
      default: next_eng = ENG_RST;
    endcase
    if (!ctl.iface_enable) next_eng = ENG_RST;
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      eng <= ENG_RST;
      cnt <= '0;
    end else if (CE_I) begin
      eng <= next_eng;
      cnt <= next_cnt;
    end
  end

  // Control register: a one written to the flag clears it, but a
  // hardware set in the same cycle wins so no event is lost.
  wire wcol_ev = wr_data & ~ctl.op_done_flag;
  always_comb begin
    next_ctl = ctl;
    if (wr_ctl) begin
      next_ctl                 = control_s'(wd);
      next_ctl.op_done_flag    = ctl.op_done_flag & ~wd[7];
      next_ctl.write_collision = ctl.write_collision;
      next_ctl.rsvd            = 1'h0;
    end
    if (wr_data) next_ctl.write_collision = wcol_ev;
    if (stop_clr) next_ctl.stop_request = 1'h0;
    if (done_set) next_ctl.op_done_flag = 1'h1;
  end

  // Data writes only land while the flag is up; a received byte lands
  // in the same cycle the flag rises.
  wire rx_load = done_set & eng.rx & ~lost & (eng.state == S_HIGH);
  wire [EV_W-1:0] events = {wcol_ev, lost, done_set};

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctl      <= control_s'(CONTROL_RST);
      data_reg <= DATA_RST;
      presc    <= '0;
    end else if (CE_I) begin
      ctl <= next_ctl;
      if (rx_load) data_reg <= eng.shift;
      else if (wr_data & ctl.op_done_flag) data_reg <= wd;
      if (wr_stat) presc <= wd[PRESC_W-1:0];
    end
  end

  // Sticky event bits; set beats a clear in the same cycle.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_st <= '0;
      irq_en <= '0;
    end else if (CE_I) begin
      irq_st <= (irq_st & ~(wr_iclr ? wd[EV_W-1:0] : '0)) | events;
      if (wr_ien) irq_en <= wd[EV_W-1:0];
    end
  end

  // The legacy enable also raises the line while the flag stands.
  assign IRQ_O = (|(irq_st & irq_en)) |
                 (ctl.irq_enable & ctl.op_done_flag);

  // Checks on the engine, next to the logic they watch.
  a_master_entry: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I) $rose(eng.master) |-> $past(eng.state == S_STA))
    else $error("master mode entered without START");
  a_start_code: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I)
    (CE_I && ctl.iface_enable && eng.state == S_STA && tick && !eng.rep)
    |=> (ctl.op_done_flag && eng.code == CODE_START && SCL_OE_O))
    else $error("START did not report 0x08");
  a_rstart_code: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I)
    (CE_I && ctl.iface_enable && eng.state == S_STA && tick && eng.rep)
    |=> (ctl.op_done_flag && eng.code == CODE_RSTART))
    else $error("repeated START did not report 0x10");
  a_wait_free: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I) (CE_I && eng.state == S_WAIT && busy)
    |=> (eng.state == S_WAIT || eng.state == S_IDLE))
    else $error("START issued on a busy bus");
  a_addr_code: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I)
    (CE_I && ctl.iface_enable && eng.state == S_HIGH && tick && last &&
     eng.addr && eng.rd) |=> (ctl.op_done_flag && (eng.code == CODE_LOST
     || eng.code == CODE_AR_ACK || eng.code == CODE_AR_NACK)))
    else $error("bad code after read address");
  a_rx_data: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I) ($rose(ctl.op_done_flag) &&
    (eng.code == CODE_RX_ACK || eng.code == CODE_RX_NACK))
    |-> data_reg == eng.shift)
    else $error("received byte missing at flag");
  a_ack_drive: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I) (CE_I && ctl.iface_enable &&
    eng.state == S_LOW && qtr && eng.rx && last)
    |=> SDA_OE_O == $past(ctl.ack_enable))
    else $error("ACK bit not per ack_enable");
  a_stop_clear: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I)
    (CE_I && ctl.iface_enable && eng.state == S_STPC && tick)
    |=> (!ctl.stop_request && !SDA_OE_O && !SCL_OE_O))
    else $error("STOP did not end cleanly");
  a_lost_free: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I) (ctl.op_done_flag && eng.code == CODE_LOST)
    |-> (!SCL_OE_O && !SDA_OE_O && !eng.master))
    else $error("bus held after arbitration loss");
  a_nack_next: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I) (CE_I && ctl.iface_enable &&
    eng.state == S_HOLD && !ctl.op_done_flag &&
    (eng.code == CODE_AR_NACK || eng.code == CODE_RX_NACK))
    |=> (eng.state == S_HOLD || eng.state == S_RSA || eng.state == S_STPA))
    else $error("byte started after NACK");
  a_hold_stretch: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I) (ctl.op_done_flag && eng.master) |-> SCL_OE_O)
    else $error("SCL released while flag set");
endmodule : twu_master_rx

// ==== verification/twu_slave_model.sv ====
/*
  Slave transmitter model for the far end of the two-wire bus.
  Assumes pull-ups on both lines: a line nobody pulls reads high.
*/
`timescale 1ns/1ps
module twu_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a  // Bus address, value is arbitrary.
) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       slow_i,
  input  wire logic       clash_i,
  output logic            scl_oe_o,
  output logic            sda_oe_o
);
  logic       ack;
  logic       tx;
  logic [2:0] idx;
  logic [7:0] rx;

  // Data follows byte_i live, so the bench may load it while SCL is held.
  assign sda_oe_o = ack | (tx & ~byte_i[idx]);

  // Optional stretch of the low half, which the master must honour.
  task automatic hold_low();
    if (slow_i) begin
      scl_oe_o = 1'b1;
      #1500;
      scl_oe_o = 1'b0;
    end
  endtask : hold_low

  // One pass per START; a repeated START simply begins the next pass.
  initial begin
    {scl_oe_o, ack, tx, idx} = '0;
    forever begin
      @(negedge sda_i iff scl_i === 1'b1);
      if (clash_i) begin
        // A rival master holds SDA low until SCL stays high, then stops.
        ack = 1'b1;
        do begin
          @(posedge scl_i);
          #1500;
        end while (scl_i !== 1'b1);
        ack = 1'b0;
        continue;
      end
      for (int i = 7; i >= 0; i--) begin
        @(posedge scl_i);
        rx[i] = sda_i;
      end
      @(negedge scl_i);
      ack = (rx[7:1] == ADDR);
      @(negedge scl_i);
      tx = ack & rx[0];
      ack = 1'b0;
      while (tx) begin
        for (int i = 7; i >= 0; i--) begin
          idx = 3'(i);
          hold_low();
          @(negedge scl_i);
        end
        tx = 1'b0;
        @(posedge scl_i);
        tx = ~sda_i;  // A NACK from the master ends the burst.
        @(negedge scl_i);
      end
    end
  end
endmodule : twu_slave_model

// ==== verification/tb_top.sv ====
/*
  Self-checking bench of the two-wire master receiver.
  Assumes one AHB-Lite slave on the bus and pull-ups on SCL and SDA.
*/
`timescale 1ns/1ps
module tb_top;
  import twu_pkg::*;
  localparam int HALF = 4;  // 800 ns link clock period.
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        slow = 1'b0, clash = 1'b0, ce = 1'b1;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = '0, hwdata = '0, r;
  logic [7:0]  sbyte = 8'h00;
  wire  [31:0] hrdata;
  wire         hready, hresp, irq, scl_oe, sda_oe, s_scl_oe, s_sda_oe;
  wire         scl_lvl, sda_lvl;
  wire         scl = ~(scl_oe | s_scl_oe);
  wire         sda = ~(sda_oe | s_sda_oe);
  int          n_fail = 0, check_count = 0, seed = 32'hed8e;
  logic [7:0]  exp_q[$];
  logic [15:0] rst_tab[6] = '{{CONTROL_OFS, CONTROL_RST},
    {STATUS_OFS, CODE_IDLE}, {DATA_OFS, DATA_RST}, {IRQ_ST_OFS, 8'h00},
    {IRQ_EN_OFS, 8'h00}, {8'h18, 8'h00}};

  // A short bus half period keeps the run brief.
  twu_master_rx #(.HALF_CYC_P(HALF)) i_twu_master_rx (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'b010), .HREADY_I(hready), .HWDATA_I(hwdata),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .SCL_I(scl), .SCL_O(scl_lvl), .SCL_OE_O(scl_oe), .SDA_I(sda),
    .SDA_O(sda_lvl),
    .SDA_OE_O(sda_oe), .IRQ_O(irq));

  twu_slave_model i_twu_slave_model (
    .scl_i(scl), .sda_i(sda), .byte_i(sbyte), .slow_i(slow),
    .clash_i(clash), .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe));

  // Core clock of 10 MHz.
  always #50 clk = ~clk;

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t pin %h exp %h", $time, got, exp);
    end
  endtask : chk_pin

  // One single transfer; the master waits on hready, giving up after a count of 50, then 100 clocks.
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 8'h00, x);
    chk_reg(x, {24'h0, e});
    chk_pin(hresp, 1'b0);
  endtask : rdc

  // The control irq_enable bit makes IRQ follow op_done_flag.
  task automatic step(input logic [7:0] ctl, input logic [7:0] code);
    int n;
    n = 0;
    wr(CONTROL_OFS, ctl);
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 3000);
    chk_pin(irq, 1'b1);
    rdc(STATUS_OFS, code);
  endtask : step

  // Reference queue of bytes sent by the far end, the last one NACKed.
  task automatic read_bytes(input int n);
    logic [7:0] b;
    for (int k = 0; k < n; k++) begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      sbyte <= b;
      slow  <= 1'($random(seed));
      if (k < n - 1) step(8'hc5, CODE_RX_ACK);
      else step(8'h85, CODE_RX_NACK);
      rdc(DATA_OFS, exp_q.pop_front());
    end
  endtask : read_bytes

  task automatic stop();
    wr(CONTROL_OFS, 8'h95);
    for (int k = 0; k < 100 && r[7:0] !== CODE_IDLE; k++)
      bus(STATUS_OFS, 1'b0, 8'h00, r);
    chk_reg(r, {24'h0, CODE_IDLE});
    bus(CONTROL_OFS, 1'b0, 8'h00, r);
    chk_pin(r[4] | scl_oe | sda_oe | scl_lvl | sda_lvl, 1'b0);
  endtask : stop

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // Watchdog: about ten times the expected length of the run.
  initial begin
    #2000000;
    n_fail++;
    complete_run();
  end

  // Main sequence: registers, interrupt, then bus transfers.
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wr(8'h18, 8'h5a);
    foreach (rst_tab[i]) rdc(rst_tab[i][15:8], rst_tab[i][7:0]);
    wr(DATA_OFS, 8'h33);
    rdc(DATA_OFS, DATA_RST);
    rdc(IRQ_ST_OFS, 8'h04);
    wr(IRQ_EN_OFS, 8'h04);
    @(posedge clk);
    chk_pin(irq, 1'b1);
    wr(IRQ_EN_OFS, 8'h00);
    @(posedge clk);
    chk_pin(irq, 1'b0);
    wr(IRQ_CLR_OFS, 8'h04);
    rdc(IRQ_ST_OFS, 8'h00);
    // Plain read burst, repeated START, then switch to writing.
    step(8'ha5, CODE_START);
    repeat (30) @(posedge clk);
    chk_pin(scl_oe, 1'b1);
    // With the enable low the block must drop a bus write entirely.
    ce <= 1'b0;
    wr(DATA_OFS, 8'h77);
    ce <= 1'b1;
    rdc(DATA_OFS, DATA_RST);
    wr(DATA_OFS, 8'h55);
    step(8'hc5, CODE_AR_ACK);
    read_bytes(2 + ($unsigned($random(seed)) % 3));
    step(8'ha5, CODE_RSTART);
    wr(DATA_OFS, 8'h54);
    step(8'h85, CODE_AW_ACK);
    stop();
    // Unanswered address: a bare clear starts no byte and SCL stays held, then STOP and START.
    step(8'ha5, CODE_START);
    wr(DATA_OFS, 8'h63);
    step(8'hc5, CODE_AR_NACK);
    wr(CONTROL_OFS, 8'h85);
    repeat (40) @(posedge clk);
    chk_pin(scl_oe, 1'b1);
    rdc(STATUS_OFS, CODE_AR_NACK);
    step(8'hb5, CODE_START);
    wr(DATA_OFS, 8'h63);
    step(8'h85, CODE_AR_NACK);
    stop();
    // Lost arbitration: release the bus, then START once it is free.
    for (int k = 0; k < 2; k++) begin
      clash <= 1'b1;
      step(8'ha5, CODE_START);
      wr(DATA_OFS, 8'h55);
      step(8'h85, CODE_LOST);
      clash <= 1'b0;
      if (k == 0) begin
        wr(CONTROL_OFS, 8'h85);
        @(posedge clk);
        chk_pin(scl_oe | sda_oe, 1'b0);
        repeat (100) @(posedge clk);
      end else begin
        step(8'ha5, CODE_START);
        wr(DATA_OFS, 8'h55);
        step(8'hc5, CODE_AR_ACK);
        read_bytes(1);
        stop();
      end
    end
    complete_run();
  end
endmodule : tb_top
